//--- bench/tb_top.sv
// self-checking bench for the zero-cross detector register block
`timescale 1ns/100ps
module tb_top
  import zcd_pkg::*;
;
  logic        sys_clk, rst, psel, penable, pwrite, target, slow, inv, f;
  logic        pready, pslverr, comparator_level, out_pin, out_pin_oe, detector_on, irq;
  logic [1:0]  m;
  logic [3:0]  pstrb;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [32:0] exp_q[$];
  int          fail_count, compares;
  zcd_regs uut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .comparator_level, .out_pin, .out_pin_oe, .detector_on, .irq);
  zcd_comparator_model cmp (.sys_clk, .target, .slow, .level(comparator_level));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input logic [32:0] got, input logic [32:0] want);
    compares++;
    if (got !== want) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
      fail_count++;
    end
  endtask : chk
  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [32:0] want);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    exp_q.push_back(want);
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      end_of_test();
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] v);
    apb(1'b0, a, 8'h00, {25'h0, v});
  endtask : rd
  task automatic sl(input logic [7:0] c, input logic [7:0] s, input logic on);
    wr(ZCD_DETECTOR_CONTROL_OFS, c);
    wr(ZCD_SLEEP_OFS, s);
    repeat (3) @(posedge sys_clk);
    chk({detector_on, out_pin_oe}, {on, on});
  endtask : sl
  // answer watcher: oldest note against each bus answer
  always @(posedge sys_clk) begin
    if (pready === 1'b1) chk({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
  end
  initial begin
    {rst, psel, penable, pwrite, target, slow} = 6'b100000;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    rnd = 32'hd920;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd(ZCD_DETECTOR_CONTROL_OFS, ZCD_CONTROL_RST);
    rd(ZCD_INTERRUPT_CONTROL_OFS, ZCD_INTERRUPT_CONTROL_RST);
    rd(ZCD_DETECTOR_STATUS_OFS, ZCD_STATUS_RST);
    rd(ZCD_INT_MASK_OFS, 8'h00);
    wr(ZCD_RESERVED_GAP_OFS, 8'hff);
    rd(ZCD_RESERVED_GAP_OFS, 8'h00);
    apb(1'b0, 12'h020, 8'h00, {1'b1, 32'h0});
    apb(1'b1, 12'h024, 8'hff, {1'b1, 32'h0});
    for (int i = 0; i < 4; i++) begin
      rnd = xs(rnd);
      wr(ZCD_DETECTOR_CONTROL_OFS, rnd[7:0]);
      rd(ZCD_DETECTOR_CONTROL_OFS, rnd[7:0] & ZCD_CONTROL_MASK);
      wr(ZCD_INTERRUPT_CONTROL_OFS, rnd[15:8]);
      rd(ZCD_INTERRUPT_CONTROL_OFS, rnd[15:8] & ZCD_INTERRUPT_CONTROL_MASK);
    end
    pstrb <= 4'he;
    wr(ZCD_DETECTOR_CONTROL_OFS, 8'hff);
    pstrb <= 4'hf;
    rd(ZCD_DETECTOR_CONTROL_OFS, rnd[7:0] & ZCD_CONTROL_MASK);
    $display("test registers finished");
    wr(ZCD_INT_MASK_OFS, 8'h01);
    for (int k = 0; k < 8; k++) begin
      m = k[1:0];
      inv = k[2];
      slow <= inv;
      wr(ZCD_DETECTOR_CONTROL_OFS, {4'h4, inv, 3'b001});
      wr(ZCD_INTERRUPT_CONTROL_OFS, {6'h0, m});
      repeat (12) @(posedge sys_clk);
      wr(ZCD_DETECTOR_STATUS_OFS, 8'h01);
      target <= 1'b1;
      repeat (12) @(posedge sys_clk);
      f = inv ? m[1] : m[0];
      rd(ZCD_DETECTOR_STATUS_OFS, {3'b0, ~inv, 3'b0, f});
      chk({out_pin_oe, out_pin, irq}, {1'b1, ~inv, f});
      wr(ZCD_INT_MASK_OFS, 8'h00);
      repeat (2) @(posedge sys_clk);
      chk(irq, 1'b0);
      wr(ZCD_INT_MASK_OFS, 8'h01);
      target <= 1'b0;
      repeat (12) @(posedge sys_clk);
      f = f | (inv ? m[0] : m[1]);
      wr(ZCD_DETECTOR_STATUS_OFS, 8'h00);
      rd(ZCD_INT_STATUS_OFS, {7'h0, f});
      chk(irq, f);
      wr(inv ? ZCD_INT_STATUS_OFS : ZCD_DETECTOR_STATUS_OFS, 8'h01);
      repeat (2) @(posedge sys_clk);
      rd(ZCD_DETECTOR_STATUS_OFS, {3'b0, inv, 4'h0});
      chk(irq, 1'b0);
    end
    $display("test edges finished");
    sl(8'h41, 8'h01, 1'b0);
    sl(8'hc1, 8'h01, 1'b1);
    sl(8'hc1, 8'h02, 1'b0);
    sl(8'hc1, 8'h00, 1'b1);
    sl(8'h00, 8'h00, 1'b0);
    $display("test sleep finished");
    end_of_test();
  end
endmodule : tb_top

//--- bench/zcd_comparator_model.sv
// comparator model: level follows the requested crossing, promptly or slowly
`timescale 1ns/100ps
module zcd_comparator_model (
  input  wire logic sys_clk,
  input  wire logic target,
  input  wire logic slow,
  output logic      level
);
  logic [3:0] dly_r;
  initial dly_r = 4'h0;
  always @(posedge sys_clk) dly_r <= {dly_r[2:0], target};
  assign level = slow ? dly_r[3] : dly_r[0];
endmodule : zcd_comparator_model

//--- bench/zcd_monitor.sv
// checker of bus answers, pin drive and interrupt of the zero-cross detector
`timescale 1ns/100ps
module zcd_monitor (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        comparator_level,
  input wire logic        out_pin,
  input wire logic        out_pin_oe,
  input wire logic        detector_on,
  input wire logic        irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire wr_acc = psel & penable & pwrite;
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready too long");
  wait_state_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer");
  ready_cause_a: assert property ($rose(pready) |-> $past(psel && penable))
    else $error("stray ready");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("stray error");
  err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read data");
  pin_on_a: assert property (out_pin_oe |-> detector_on)
    else $error("pin driven while off");
  pin_idle_a: assert property (!out_pin_oe |-> !out_pin)
    else $error("pin level while idle");
  irq_clear_a: assert property ($fell(irq) |->
    $past(wr_acc) || $past(wr_acc, 2) || $past(wr_acc, 3)) else $error("irq fell alone");
  on_write_a: assert property ($changed(detector_on) |->
    $past(wr_acc) || $past(wr_acc, 2)) else $error("on changed alone");
endmodule : zcd_monitor
bind zcd_regs zcd_monitor mon (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .prdata, .pready, .pslverr, .comparator_level, .out_pin, .out_pin_oe,
  .detector_on, .irq);

//--- hdl/zcd_pkg.sv
// package with register map, field positions and reset values of the zero-cross detector
package zcd_pkg;
  // ---------------------------------------------------------------------------
  // register word indices; each register takes one aligned word at four times its index
  // ---------------------------------------------------------------------------
  localparam logic [9:0]  ZCD_DETECTOR_CONTROL_IDX   = 10'h000;
  localparam logic [9:0]  ZCD_RESERVED_GAP_IDX       = 10'h001;
  localparam logic [9:0]  ZCD_INTERRUPT_CONTROL_IDX  = 10'h002;
  localparam logic [9:0]  ZCD_DETECTOR_STATUS_IDX    = 10'h003;
  localparam logic [9:0]  ZCD_INT_MASK_IDX           = 10'h004;
  localparam logic [9:0]  ZCD_INT_STATUS_IDX         = 10'h005;
  localparam logic [9:0]  ZCD_SLEEP_IDX              = 10'h006;
  localparam logic [11:0] ZCD_DETECTOR_CONTROL_OFS   = {ZCD_DETECTOR_CONTROL_IDX, 2'b00};
  localparam logic [11:0] ZCD_RESERVED_GAP_OFS       = {ZCD_RESERVED_GAP_IDX, 2'b00};
  localparam logic [11:0] ZCD_INTERRUPT_CONTROL_OFS  = {ZCD_INTERRUPT_CONTROL_IDX, 2'b00};
  localparam logic [11:0] ZCD_DETECTOR_STATUS_OFS    = {ZCD_DETECTOR_STATUS_IDX, 2'b00};
  localparam logic [11:0] ZCD_INT_MASK_OFS           = {ZCD_INT_MASK_IDX, 2'b00};
  localparam logic [11:0] ZCD_INT_STATUS_OFS         = {ZCD_INT_STATUS_IDX, 2'b00};
  localparam logic [11:0] ZCD_SLEEP_OFS              = {ZCD_SLEEP_IDX, 2'b00};
  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int ZCD_ENABLE_BIT          = 0;
  localparam int ZCD_INVERT_BIT          = 3;
  localparam int ZCD_OUTPUT_PIN_EN_BIT   = 6;
  localparam int ZCD_RUN_IN_STANDBY_BIT  = 7;
  localparam int ZCD_CROSS_FLAG_BIT      = 0;
  localparam int ZCD_STATE_BIT           = 4;
  localparam int ZCD_STANDBY_BIT         = 0;
  localparam int ZCD_POWER_DOWN_BIT      = 1;
  // ---------------------------------------------------------------------------
  // reset values and masks
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ZCD_CONTROL_RST   = 8'h00;
  localparam logic [7:0] ZCD_CONTROL_MASK  = 8'hc9;
  localparam logic [7:0] ZCD_INTERRUPT_CONTROL_RST   = 8'h00;
  localparam logic [7:0] ZCD_INTERRUPT_CONTROL_MASK  = 8'h03;
  localparam logic [7:0] ZCD_STATUS_RST    = 8'h00;
  localparam logic [0:0] ZCD_MASK_RST      = 1'h0;
  localparam int         ZCD_SYNC_STAGES   = 3;
  // ---------------------------------------------------------------------------
  // interrupt edge select encodings
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ZCD_EDGE_NONE    = 2'b00,
    ZCD_EDGE_RISING  = 2'b01,
    ZCD_EDGE_FALLING = 2'b10,
    ZCD_EDGE_BOTH    = 2'b11
  } zcd_edge_t;
  // ---------------------------------------------------------------------------
  // bus slave states
  // ---------------------------------------------------------------------------
  typedef enum logic [0:0] {
    ZCD_BUS_IDLE = 1'b0,
    ZCD_BUS_DONE = 1'b1
  } zcd_bus_t;
endpackage : zcd_pkg

//--- hdl/zcd_regs.sv
// register bank, edge interrupt and pin drive of the zero-cross detector
//
// Overview of operation
// - control bit 0 switches the detector on and off
// - control bit 3 inverts the detector output for all uses
// - control bit 6 drives the detector output onto its pin
// - control bit 7 keeps the detector running in standby sleep
// - interrupt control bits 1:0 pick none, rising, falling or both edges
// - status bit 4 shows the output level after three synchroniser cycles
// - writing one to status bit 0 clears the cross flag, zero does nothing
// - the selected edge on the output sets the cross flag
// - interrupt request is high while mode is non-zero, flag is set and the interrupt mask bit is set
// - power-down sleep disables the detector and its pin drive completely
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
module zcd_regs
  import zcd_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        comparator_level,
  output logic             out_pin,
  output logic             out_pin_oe,
  output logic             detector_on,
  output logic             irq
);
  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [7:0]  control_r,    control_nxt;
  logic [1:0]  edge_sel_r,   edge_sel_nxt;
  logic        cross_flag_r, cross_flag_nxt;
  logic        prev_level_r, prev_level_nxt;
  logic        standby_r,    standby_nxt;
  logic        pdown_r,      pdown_nxt;
  logic        mask_r,       mask_nxt;
  logic [31:0] prdata_r,     prdata_nxt;
  logic        pslverr_r,    pslverr_nxt;
  logic        pin_r,        pin_nxt;
  logic        pin_oe_r,     pin_oe_nxt;
  logic        on_r,         on_nxt;
  logic        irq_r,        irq_nxt;
  zcd_bus_t    bus_r,        bus_nxt;

  logic        active;
  logic        out_level;
  logic        synced;
  logic        rise;
  logic        fall;
  logic        edge_hit;
  logic        wr_en;
  logic        rd_en;
  logic        mapped;
  logic [31:0] rd_word;
  logic        clear_hit;

  zcd_sync_if sif ();

  // ---------------------------------------------------------------------------
  // detector path
  // ---------------------------------------------------------------------------
  // the detector runs when enabled, not in power-down, and not in standby
  // unless told to stay on
  assign active = control_r[ZCD_ENABLE_BIT]
                & ~pdown_r
                & (~standby_r | control_r[ZCD_RUN_IN_STANDBY_BIT]);

  assign out_level = active & (comparator_level ^ control_r[ZCD_INVERT_BIT]);
  assign sif.raw_level = out_level;

  zcd_sync #(
    .STAGES (ZCD_SYNC_STAGES)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .sif     (sif.sink)
  );

  assign synced = sif.synced_level;
  assign rise   = synced & ~prev_level_r;
  assign fall   = ~synced & prev_level_r;

  always_comb begin
    case (zcd_edge_t'(edge_sel_r))
      ZCD_EDGE_NONE:    edge_hit = 1'b0;
      ZCD_EDGE_RISING:  edge_hit = rise;
      ZCD_EDGE_FALLING: edge_hit = fall;
      ZCD_EDGE_BOTH:    edge_hit = rise | fall;
      default:          edge_hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  assign wr_en = psel & penable & pwrite & (bus_r == ZCD_BUS_IDLE);
  assign rd_en = psel & penable & ~pwrite & (bus_r == ZCD_BUS_IDLE);
  assign clear_hit = wr_en & pstrb[0] & pwdata[ZCD_CROSS_FLAG_BIT]
                   & ((paddr == ZCD_DETECTOR_STATUS_OFS) | (paddr == ZCD_INT_STATUS_OFS));

  always_comb begin
    mapped  = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      ZCD_DETECTOR_CONTROL_OFS:  rd_word = {24'h00_0000, control_r & ZCD_CONTROL_MASK};
      ZCD_RESERVED_GAP_OFS:      rd_word = 32'h0000_0000;
      ZCD_INTERRUPT_CONTROL_OFS: rd_word = {30'h0000_0000, edge_sel_r};
      ZCD_DETECTOR_STATUS_OFS:   rd_word = {27'h000_0000, synced, 3'h0, cross_flag_r};
      ZCD_INT_MASK_OFS:          rd_word = {31'h0000_0000, mask_r};
      ZCD_INT_STATUS_OFS:        rd_word = {31'h0000_0000, cross_flag_r};
      ZCD_SLEEP_OFS:             rd_word = {30'h0000_0000, pdown_r, standby_r};
      default:                   mapped = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------------------
  always_comb begin
    control_nxt  = control_r;
    edge_sel_nxt = edge_sel_r;
    standby_nxt  = standby_r;
    pdown_nxt    = pdown_r;
    mask_nxt     = mask_r;
    // a write with the low byte lane off leaves every register as it is
    if (wr_en && pstrb[0]) begin
      case (paddr)
        ZCD_DETECTOR_CONTROL_OFS: begin
          control_nxt = pwdata[7:0] & ZCD_CONTROL_MASK;
        end
        ZCD_INTERRUPT_CONTROL_OFS: begin
          edge_sel_nxt = pwdata[1:0];
        end
        ZCD_INT_MASK_OFS: begin
          mask_nxt = pwdata[0];
        end
        ZCD_SLEEP_OFS: begin
          standby_nxt = pwdata[ZCD_STANDBY_BIT];
          pdown_nxt   = pwdata[ZCD_POWER_DOWN_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      control_r  <= ZCD_CONTROL_RST;
      edge_sel_r <= ZCD_INTERRUPT_CONTROL_RST[1:0];
      standby_r  <= 1'b0;
      pdown_r    <= 1'b0;
      mask_r     <= ZCD_MASK_RST;
    end else begin
      control_r  <= control_nxt;
      edge_sel_r <= edge_sel_nxt;
      standby_r  <= standby_nxt;
      pdown_r    <= pdown_nxt;
      mask_r     <= mask_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // cross flag and previous synchronised sample
  // ---------------------------------------------------------------------------
  always_comb begin
    cross_flag_nxt = cross_flag_r;
    prev_level_nxt = synced;
    if (clear_hit) begin
      cross_flag_nxt = 1'b0;
    end
    // a new edge outranks a clear in the same cycle
    if (edge_hit) begin
      cross_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cross_flag_r <= 1'b0;
      prev_level_r <= 1'b0;
    end else begin
      cross_flag_r <= cross_flag_nxt;
      prev_level_r <= prev_level_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // bus slave answer, one wait state
  // ---------------------------------------------------------------------------
  always_comb begin
    bus_nxt     = ZCD_BUS_IDLE;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    if (wr_en || rd_en) begin
      bus_nxt     = ZCD_BUS_DONE;
      pslverr_nxt = ~mapped;
    end
    // unmapped reads return zero from the decode default
    if (rd_en) begin
      prdata_nxt = rd_word;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_r     <= ZCD_BUS_IDLE;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      bus_r     <= bus_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  always_comb begin
    pin_oe_nxt = active & control_r[ZCD_OUTPUT_PIN_EN_BIT];
    pin_nxt    = pin_oe_nxt & out_level;
    on_nxt     = active;
    irq_nxt    = (edge_sel_r != ZCD_EDGE_NONE) & cross_flag_r & mask_r;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_r    <= 1'b0;
      pin_oe_r <= 1'b0;
      on_r     <= 1'b0;
      irq_r    <= 1'b0;
    end else begin
      pin_r    <= pin_nxt;
      pin_oe_r <= pin_oe_nxt;
      on_r     <= on_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign prdata      = prdata_r;
  assign pready      = (bus_r == ZCD_BUS_DONE);
  assign pslverr     = pslverr_r;
  assign out_pin     = pin_r;
  assign out_pin_oe  = pin_oe_r;
  assign detector_on = on_r;
  assign irq         = irq_r;
endmodule : zcd_regs

//--- hdl/zcd_sync.sv
// multi-stage synchroniser for the comparator output level
`timescale 1ns/100ps
module zcd_sync
  import zcd_pkg::*;
#(
  parameter int STAGES = ZCD_SYNC_STAGES
) (
  input  wire logic  sys_clk,
  input  wire logic  rst,
  zcd_sync_if.sink   sif
);
  logic [STAGES-1:0] chain_r;
  logic [STAGES-1:0] chain_nxt;

  always_comb begin
    chain_nxt = {chain_r[STAGES-2:0], sif.raw_level};
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chain_r <= '0;
    end else begin
      chain_r <= chain_nxt;
    end
  end

  assign sif.synced_level = chain_r[STAGES-1];
endmodule : zcd_sync

//--- hdl/zcd_sync_if.sv
// interface carrying the gated, optionally inverted detector output level into the synchroniser and the result back
`timescale 1ns/100ps
interface zcd_sync_if;
  logic raw_level;
  logic synced_level;
  modport sink   (input raw_level, output synced_level);
  modport source (output raw_level, input synced_level);
endinterface : zcd_sync_if
